// [shared/u4sr_params.svh]
`ifndef U4SR_PARAMS_SVH
`define U4SR_PARAMS_SVH

// Register stage count
`define U4SR_STAGES 4

// Bus geometry
`define U4SR_AXI_AW 4
`define U4SR_AXI_DW 32

// Word offsets (byte addresses)
`define U4SR_ADDR_CTRL 4'h0
`define U4SR_ADDR_STATUS 4'h4

// Control register fields
`define U4SR_CTRL_VARIANT_BIT 0
`define U4SR_CTRL_RESET 1'h0

// Status register fields
`define U4SR_STAT_STAGES_LSB 0
`define U4SR_STAT_COMP_BIT 4
`define U4SR_STAT_CLEAR_N_BIT 5

// Response codes
`define U4SR_RESP_OKAY 2'h0
`define U4SR_RESP_DECERR 2'h3

`endif

// [shared/u4sr_pkg.sv]
package u4sr_pkg;

  // Synchronous operation chosen for the next clock edge
  typedef enum logic [1:0] {
    op_load,
    op_shift,
    op_hold
  } u4sr_op_t;

  // Register selected by a bus address
  typedef enum logic [1:0] {
    sel_ctrl,
    sel_status,
    sel_none
  } u4sr_sel_t;

endpackage : u4sr_pkg

// [verilog/u4sr_stage_next.sv]
`timescale 1ns/1ps
`include "u4sr_params.svh"

module u4sr_stage_next (
  input wire logic [3:0] cur,
  input wire logic [3:0] par_in,
  input wire logic serial_bit,
  input wire u4sr_pkg::u4sr_op_t op,
  output logic [3:0] nxt
);

  genvar i;
  generate
    for (i = 0; i < `U4SR_STAGES; i = i + 1) begin : g_stage
      logic shift_src;
      if (i == 0) begin : g_first
        assign shift_src = serial_bit;
      end else begin : g_rest
        assign shift_src = cur[i-1];
      end
      always_comb begin
        case (op)
          u4sr_pkg::op_load: nxt[i] = par_in[i];
          u4sr_pkg::op_shift: nxt[i] = shift_src;
          default: nxt[i] = cur[i];
        endcase
      end
    end
  endgenerate

endmodule : u4sr_stage_next

// [verilog/u4sr_axil.sv]
`timescale 1ns/1ps
`include "u4sr_params.svh"

module u4sr_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] status_word,
  output logic ctrl_variant
);

  function automatic u4sr_pkg::u4sr_sel_t decode(input logic [3:0] a);
    if (a[3:2] == `U4SR_ADDR_CTRL >> 2) begin
      decode = u4sr_pkg::sel_ctrl;
    end else if (a[3:2] == `U4SR_ADDR_STATUS >> 2) begin
      decode = u4sr_pkg::sel_status;
    end else begin
      decode = u4sr_pkg::sel_none;
    end
  endfunction : decode

  logic aw_full, next_aw_full, w_full, next_w_full;
  logic [3:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic w_lane0, next_w_lane0;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic ctrl, next_ctrl;

  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign ctrl_variant = ctrl;

  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_ctrl = ctrl;
    if (s_axi_awvalid && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // Commit only once both halves are held and the last answer is gone
    if (aw_full && w_full && !bvalid) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `U4SR_RESP_OKAY;
      if (decode(aw_addr) == u4sr_pkg::sel_ctrl) begin
        if (w_lane0) begin
          next_ctrl = w_data[`U4SR_CTRL_VARIANT_BIT];
        end
      end else if (decode(aw_addr) == u4sr_pkg::sel_none) begin
        next_bresp = `U4SR_RESP_DECERR;
      end
    end
  end

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = `U4SR_RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (decode(s_axi_araddr) == u4sr_pkg::sel_ctrl) begin
        next_rdata[`U4SR_CTRL_VARIANT_BIT] = ctrl;
      end else if (decode(s_axi_araddr) == u4sr_pkg::sel_status) begin
        next_rdata = status_word;
      end else begin
        next_rresp = `U4SR_RESP_DECERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= 4'h0;
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `U4SR_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `U4SR_RESP_OKAY;
      ctrl <= `U4SR_CTRL_RESET;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      ctrl <= next_ctrl;
    end
  end

endmodule : u4sr_axil

// [verilog/u4sr_top.sv]
// Contract
// - Edge-triggered, non-transparent: outputs use inputs sampled before the edge.
// - Four stages, each with parallel input and true output; last also inverted.
// - Synchronous serial shift and synchronous parallel load, chosen by a control input.
// - Active-low master clear acts without the clock and overrides everything.
// - Master clear low forces all four stages to zero.
// - Base variant feeds the first stage from a two-line set/clear pair.
// - Base variant loads when the load select is low, shifts when high.
// - Shift moves one place per rising edge: stage n takes stage n-1.
// - Outputs change only on the rising edge, apart from master clear.
// - Hold variant offers exactly shift, parallel load and hold.
// - Hold variant: hold enable high blocks shift and load, keeping contents.
// - Hold variant uses one data serial input for the first stage.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "u4sr_params.svh"

module u4sr_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic master_clear_n,
  input wire logic parallel_load_select_n,
  input wire logic hold_enable,
  input wire logic serial_set,
  input wire logic serial_clear_n,
  input wire logic serial_data,
  input wire logic [3:0] stage_parallel_in,
  output logic [3:0] stage_out,
  output logic stage3_out_n,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Variant chosen by software: 0 two-line serial input, 1 hold-capable
  logic hold_variant;
  logic [3:0] stages;
  logic [3:0] next_stages;
  logic stage3_n;
  logic next_stage3_n;
  logic first_serial;
  u4sr_pkg::u4sr_op_t op;
  logic [31:0] status_word;

  // Set/clear pair behaves as a JK input with the clear line inverted
  function automatic logic set_clear_next(input logic set_in, input logic clr_n,
                                          input logic cur);
    set_clear_next = (set_in & ~cur) | (clr_n & cur);
  endfunction : set_clear_next

  // Protection bits carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

  u4sr_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .status_word(status_word),
    .ctrl_variant(hold_variant)
  );

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`U4SR_STAT_STAGES_LSB +: 4] = stages;
    status_word[`U4SR_STAT_COMP_BIT] = stage3_n;
    status_word[`U4SR_STAT_CLEAR_N_BIT] = master_clear_n;
  end

  always_comb begin
    if (hold_variant && hold_enable) begin
      op = u4sr_pkg::op_hold;
    end else if (!parallel_load_select_n) begin
      op = u4sr_pkg::op_load;
    end else begin
      op = u4sr_pkg::op_shift;
    end
  end

  // single data line in hold variant
  always_comb begin
    if (hold_variant) begin
      first_serial = serial_data;
    end else begin
      first_serial = set_clear_next(serial_set, serial_clear_n, stages[0]);
    end
  end

  u4sr_stage_next u_next (
    .cur(stages),
    .par_in(stage_parallel_in),
    .serial_bit(first_serial),
    .op(op),
    .nxt(next_stages)
  );

  // inverted copy of the last stage
  always_comb begin
    next_stage3_n = ~next_stages[3];
  end

  // change on the rising edge, or at once when master clear goes low
  always_ff @(posedge aclk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      stages <= 4'h0;
      stage3_n <= 1'b1;
    end else if (!aresetn) begin
      stages <= 4'h0;
      stage3_n <= 1'b1;
    end else begin
      stages <= next_stages;
      stage3_n <= next_stage3_n;
    end
  end

  assign stage_out = stages;
  assign stage3_out_n = stage3_n;

  // Load, shift, set/clear and hold checks below are only meaningful while neither clear is active
  logic run;
  assign run = aresetn && master_clear_n;

  default clocking cb @(posedge aclk);
  endclocking

  default disable iff (!aresetn);

  sequence s_load_cycle;
    run && op == u4sr_pkg::op_load;
  endsequence

  sequence s_shift_cycle;
    run && op == u4sr_pkg::op_shift;
  endsequence

  sequence s_hold_cycle;
    run && op == u4sr_pkg::op_hold;
  endsequence

  AST_LOAD: assert property (
    s_load_cycle ##1 run |-> stages == $past(stage_parallel_in)
  ) else $error("parallel load did not capture inputs");

  AST_SHIFT: assert property (
    s_shift_cycle ##1 run |-> stages[3:1] == $past(stages[2:0])
  ) else $error("shift did not move stages by one");

  AST_LOAD_THEN_SHIFT: assert property (
    s_load_cycle ##1 s_shift_cycle ##1 run
      |-> stages[3:1] == $past(stage_parallel_in[2:0], 2)
  ) else $error("load then shift sequence lost data");

  AST_SET_CLEAR: assert property (
    s_shift_cycle ##0 !hold_variant ##1 run |->
      stages[0] == (($past(serial_set) & ~$past(stages[0]))
                    | ($past(serial_clear_n) & $past(stages[0])))
  ) else $error("first stage set/clear result wrong");

  // both lines low clears first stage
  AST_SC_CLEAR: assert property (
    s_shift_cycle ##0 (!hold_variant && !serial_set && !serial_clear_n) ##1 run
      |-> !stages[0]
  ) else $error("set/clear pair low did not clear first stage");

  AST_DATA_IN: assert property (
    s_shift_cycle ##0 hold_variant ##1 run |-> stages[0] == $past(serial_data)
  ) else $error("serial data not shifted into first stage");

  AST_HOLD: assert property (
    s_hold_cycle ##1 run |-> $stable(stages)
  ) else $error("hold enable did not retain contents");

  // hold only exists in the hold variant
  AST_HOLD_SRC: assert property (
    op == u4sr_pkg::op_hold |-> hold_variant && hold_enable
  ) else $error("hold chosen without hold variant and enable");

  AST_CLEAR: assert property (
    !master_clear_n |-> stages == 4'h0 && stage3_n
  ) else $error("master clear did not zero stages");

  AST_CLEAR_WINS: assert property (
    (!master_clear_n && !parallel_load_select_n) [*2] |-> stage_out == 4'h0
  ) else $error("load overrode master clear");

  AST_COMP: assert property (
    stage3_out_n == ~stage_out[3]
  ) else $error("inverted last stage output mismatched");

  AST_SYNC: assert property (
    run && $past(run) && $past(op) == u4sr_pkg::op_hold |-> $stable(stage_out)
  ) else $error("outputs changed during hold");

  // outputs depend on values before the edge
  AST_NO_RACE: assert property (
    s_shift_cycle ##1 run |-> stages[1] == $past(stage_out[0])
  ) else $error("shift used post-edge value");

  AST_LOAD_SEL: assert property (
    !hold_variant && !parallel_load_select_n |-> op == u4sr_pkg::op_load
  ) else $error("load select low did not choose load");

  AST_SHIFT_SEL: assert property (
    parallel_load_select_n && !(hold_variant && hold_enable) |-> op == u4sr_pkg::op_shift
  ) else $error("load select high did not choose shift");

  AST_HOLD_PRIO: assert property (
    hold_variant && hold_enable |-> op == u4sr_pkg::op_hold
  ) else $error("hold enable did not choose hold");

  AST_BASE_NO_HOLD: assert property (
    !hold_variant |-> op != u4sr_pkg::op_hold
  ) else $error("base variant chose hold");

  AST_SC_SET: assert property (
    s_shift_cycle ##0 (!hold_variant && serial_set && serial_clear_n) ##1 run
      |-> stages[0]
  ) else $error("set/clear pair high did not set first stage");

  AST_SC_KEEP: assert property (
    s_shift_cycle ##0 (!hold_variant && !serial_set && serial_clear_n) ##1 run
      |-> stages[0] == $past(stages[0])
  ) else $error("set/clear pair did not keep first stage");

  AST_SC_TOGGLE: assert property (
    s_shift_cycle ##0 (!hold_variant && serial_set && !serial_clear_n) ##1 run
      |-> stages[0] != $past(stages[0])
  ) else $error("set/clear pair did not toggle first stage");

  AST_CLEAR_COMP: assert property (
    !master_clear_n |-> stage3_out_n
  ) else $error("master clear left complement low");

  AST_STATUS: assert property (
    status_word[3:0] == stage_out && status_word[5] == master_clear_n
  ) else $error("status word does not mirror stages");

  // Answers stand until the master takes them
  AST_BRESP_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
  ) else $error("write response dropped before taken");

  AST_RDATA_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
  ) else $error("read data dropped before taken");

endmodule : u4sr_top

// [dv/u4sr_user_model.sv]
`timescale 1ns/1ps

module u4sr_user_model (
  input wire logic aclk,
  input wire logic [8:0] cmd,
  output logic parallel_load_select_n,
  output logic hold_enable,
  output logic serial_set,
  output logic serial_clear_n,
  output logic serial_data,
  output logic [3:0] stage_parallel_in
);
  logic [8:0] pins = 9'h000;

  // User logic is synchronous: its pins only move just after a rising edge
  always @(posedge aclk) begin
    pins <= cmd;
  end

  assign {parallel_load_select_n, hold_enable, serial_set, serial_clear_n} = pins[8:5];
  assign serial_data = pins[4];
  assign stage_parallel_in = pins[3:0];
endmodule : u4sr_user_model

// [dv/u4sr_tb_top.sv]
`timescale 1ns/1ps

module u4sr_tb_top;
  logic aclk;
  logic aresetn;
  logic master_clear_n;
  logic [8:0] cmd;
  logic pl_n, hold, sset, sclr_n, sdat;
  logic [3:0] pin, q, awaddr, araddr, wstrb;
  logic q3_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int fails, num_checks, m_q, m_var, s;

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  u4sr_user_model u4sr_user_model_inst (.aclk(aclk), .cmd(cmd),
    .parallel_load_select_n(pl_n), .hold_enable(hold), .serial_set(sset),
    .serial_clear_n(sclr_n), .serial_data(sdat), .stage_parallel_in(pin));

  u4sr_top u4sr_top_inst (.aclk(aclk), .aresetn(aresetn), .master_clear_n(master_clear_n),
    .parallel_load_select_n(pl_n), .hold_enable(hold), .serial_set(sset),
    .serial_clear_n(sclr_n), .serial_data(sdat), .stage_parallel_in(pin), .stage_out(q),
    .stage3_out_n(q3_n), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  always @(posedge aclk or negedge master_clear_n) begin
    if (!aresetn) m_var = 0;
    s = sset ? (sclr_n ? 1 : 1 - (m_q & 1)) : (sclr_n ? (m_q & 1) : 0);
    if (!master_clear_n || !aresetn) m_q = 0;
    else if (m_var == 1 && hold) m_q = m_q;
    else if (!pl_n) m_q = pin;
    else if (m_var == 1) m_q = ((m_q << 1) | sdat) & 15;
    else m_q = ((m_q << 1) | s) & 15;
  end

  task automatic chk_stage(input string nm, input logic [4:0] e, input logic [4:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_stage

  task automatic chk_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_bus

  // Settled values are compared away from the launching edge
  always @(negedge aclk) begin
    chk_stage("stages", {~m_q[3], m_q[3:0]}, {q3_n, q});
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st,
      input logic [1:0] er);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 40);
    bready <= 1'b0;
    if (bvalid !== 1'b1) begin
      fails++;
      give_verdict();
    end
    chk_bus("bresp", {30'h0, er}, {30'h0, bresp});
    if (a == 4'h0 && st[0]) m_var = d[0];
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 40);
    rready <= 1'b0;
    if (rvalid !== 1'b1) begin
      fails++;
      give_verdict();
    end
    chk_bus("rdata", ed, rdata);
    chk_bus("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : axi_rd

  initial begin
    aresetn = 1'b0;
    master_clear_n = 1'b1;
    cmd = 9'h000;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    void'($urandom(32'hC9294218));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(4'h0, 32'h0, 2'h0);
    axi_rd(4'h4, 32'h30, 2'h0);
    $display("test reset_values done");
    @(posedge aclk);
    cmd <= 9'h005;
    @(posedge aclk);
    cmd <= 9'h160;
    repeat (2) @(posedge aclk);
    #1 chk_stage("walk", 5'h0B, {q3_n, q});
    $display("test load_then_shift done");
    // Base variant: every mode and set/clear code
    repeat (300) begin
      @(posedge aclk);
      cmd <= 9'($urandom);
    end
    $display("test random_base done");
    @(posedge aclk);
    cmd <= 9'h00A;
    repeat (3) @(posedge aclk);
    axi_wr(4'h8, 32'h1, 4'hF, 2'h3);
    axi_rd(4'hC, 32'h0, 2'h3);
    axi_wr(4'h4, 32'h0, 4'hF, 2'h0);
    axi_rd(4'h4, 32'h2A, 2'h0);
    axi_wr(4'h0, 32'h1, 4'hF, 2'h0);
    axi_wr(4'h0, 32'h0, 4'hE, 2'h0);
    axi_rd(4'h0, 32'h1, 2'h0);
    $display("test registers done");
    // Hold variant, then a reset in mid-run drops it back to base
    repeat (300) begin
      @(posedge aclk);
      cmd <= 9'($urandom);
    end
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      cmd <= 9'($urandom);
    end
    $display("test random_hold done");
    @(posedge aclk);
    cmd <= 9'h00F;
    repeat (3) @(posedge aclk);
    master_clear_n <= 1'b0;
    #1 chk_stage("async_clear", 5'h10, {q3_n, q});
    repeat (20) begin
      @(posedge aclk);
      cmd <= 9'($urandom);
    end
    axi_rd(4'h4, 32'h10, 2'h0);
    master_clear_n <= 1'b1;
    repeat (20) @(posedge aclk);
    $display("test master_clear done");
    give_verdict();
  end
endmodule : u4sr_tb_top
